// ---- bench/cmrs_core_sva.sv ----
// Port-level checker for the execution block.
`timescale 1ns/1ps
module cmrs_core_sva import cmrs_pkg::*; (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [PADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic OSC_RUN_OUT,
  input wire logic SLEEPING_OUT,
  input wire logic GIE_OUT
);
  // ---------------------------------------------------------------
  // Helper terms
  // ---------------------------------------------------------------
  logic wr_commit;
  logic instr_commit;
  logic sleep_cmd;
  logic irq_cmd;
  logic nop_cmd;
  logic stat_commit;
  logic wake_commit;
  assign wr_commit = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
  assign instr_commit = wr_commit && (PADDR_IN == OFF_INSTR);
  assign sleep_cmd = instr_commit && (PWDATA_IN[13:0] == OPC_SLEEP);
  assign irq_cmd = instr_commit && (PWDATA_IN[13:0] == OPC_RET_IRQ);
  assign nop_cmd = instr_commit && (PWDATA_IN[13:7] == 7'h00) &&
    (PWDATA_IN[4:0] == 5'h00);
  assign stat_commit = wr_commit && (PADDR_IN == OFF_STATUS);
  assign wake_commit = wr_commit && (PADDR_IN == OFF_CTRL) &&
    PWDATA_IN[CTB_WAKE];

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence
  sequence s_go_sleep;
    sleep_cmd && !SLEEPING_OUT;
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_ready_wait:
    assert property (s_setup ##1 s_access |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("ready not a single pulse after one wait state");
  chk_osc_vs_sleep:
    assert property (OSC_RUN_OUT != SLEEPING_OUT)
    else $error("oscillator runs while asleep");
  chk_sleep_enter:
    assert property (s_go_sleep |=> !SLEEPING_OUT ##1
      (SLEEPING_OUT && !OSC_RUN_OUT))
    else $error("sleep not entered at the execute edge");
  chk_sleep_hold:
    assert property (SLEEPING_OUT && !wake_commit && !$past(wake_commit)
      |=> SLEEPING_OUT)
    else $error("sleep left without a wake write");
  chk_osc_stop_cause:
    assert property ($fell(OSC_RUN_OUT) |-> $past(sleep_cmd, 2))
    else $error("oscillator stopped without a sleep opcode");
  chk_gie_on_ret:
    assert property (irq_cmd && !SLEEPING_OUT |=> $stable(GIE_OUT) ##1
      GIE_OUT)
    else $error("global enable not set by return from irq");
  chk_gie_cause:
    assert property ($changed(GIE_OUT) |-> $past(stat_commit) ||
      $past(irq_cmd, 2))
    else $error("global enable changed without cause");
  chk_nop_quiet:
    assert property (nop_cmd && !SLEEPING_OUT |=>
      (!SLEEPING_OUT && $stable(GIE_OUT))[*3])
    else $error("no-operation changed core state");
endmodule

bind cmrs_core cmrs_core_sva u_chk (
  .CLK_IN(CLK_IN),
  .RSTN_IN(RSTN_IN),
  .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT),
  .OSC_RUN_OUT(OSC_RUN_OUT),
  .SLEEPING_OUT(SLEEPING_OUT),
  .GIE_OUT(GIE_OUT)
);

// ---- bench/tb_top.sv ----
// Self-checking testbench for the execution block over APB.
`timescale 1ns/1ps
module tb_top import cmrs_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_run;
  logic sleeping;
  logic global_irq_enable;
  logic [32:0] exp_q[$];
  int bad_count = 0;
  int samples_checked = 0;
  int seed = 32'hfa58;

  cmrs_core uut (.CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .OSC_RUN_OUT(osc_run),
    .SLEEPING_OUT(sleeping), .GIE_OUT(global_irq_enable));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Read data is judged here, at the edge that completes the read.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() > 0) begin
        check(exp_q.pop_front(), {pslverr, prdata});
      end else begin
        bad_count++;
      end
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask
  // Idle cycles let a two-cycle return finish before the next commit.
  task automatic op(input logic [13:0] o);
    apb(1'b1, OFF_INSTR, {18'h0, o});
    repeat (3) @(posedge clk);
  endtask
  task automatic fset(input logic [6:0] a, input logic [7:0] v);
    wr(OFF_FADDR, {25'h0, a});
    wr(OFF_FDATA, {24'h0, v});
  endtask
  task automatic fchk(input logic [6:0] a, input logic [7:0] v);
    wr(OFF_FADDR, {25'h0, a});
    rd(OFF_FDATA, {24'h0, v});
  endtask
  task automatic ports(input logic [2:0] e);
    check({30'h0, e}, {30'h0, sleeping, osc_run, global_irq_enable});
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0] v;
    logic [7:0] res;
    logic [6:0] a;
    logic [12:0] t1;
    logic [12:0] t2;
    logic d;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(OFF_STATUS, 32'h0c);
    rd(OFF_ACC, 32'h0);
    ports(3'b010);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(OFF_STATUS, {30'h0, i[1:0]});
      op({PAT_LOAD_LIT, i[1:0], r[7:0]});
      rd(OFF_ACC, {24'h0, r[7:0]});
      rd(OFF_STATUS, {30'h0, i[1:0]});
    end
    done("load_literal");
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      d = i[0];
      a = (i == 1) ? 7'h7f : r[14:8];
      v = (i < 2) ? 8'h00 : (r[7:0] | 8'h01);
      wr(OFF_STATUS, {30'h0, v != 8'h00, 1'b1});
      wr(OFF_ACC, {24'h0, ~v});
      fset(a, v);
      op({PAT_COPY_FILE, d, a});
      rd(OFF_ACC, {24'h0, d ? ~v : v});
      fchk(a, v);
      rd(OFF_STATUS, {30'h0, v == 8'h00, 1'b1});
    end
    done("copy_file_reg");
    for (int i = 0; i < 2; i++) begin
      r = $random(seed);
      a = i[0] ? 7'h7f : r[14:8];
      wr(OFF_STATUS, 32'h3);
      wr(OFF_ACC, {24'h0, r[7:0]});
      fset(a, ~r[7:0]);
      op({PAT_STORE_ACC, a});
      fchk(a, r[7:0]);
      rd(OFF_STATUS, 32'h3);
    end
    done("store_accumulator");
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      d = i[0];
      a = r[14:8];
      v = r[7:0];
      res = {v[6:0], i[1]};
      wr(OFF_STATUS, {30'h0, 1'b1, i[1]});
      wr(OFF_ACC, {24'h0, ~v});
      fset(a, v);
      op({PAT_ROTATE, d, a});
      rd(OFF_ACC, {24'h0, d ? ~v : res});
      fchk(a, d ? res : v);
      rd(OFF_STATUS, {30'h0, 1'b1, v[7]});
    end
    done("rotate_left_via_carry");
    r = $random(seed);
    t1 = r[12:0];
    t2 = r[28:16];
    wr(OFF_STATUS, 32'h1);
    wr(OFF_STACK, {19'h0, t1});
    wr(OFF_STACK, {19'h0, t2});
    op({PAT_RET_LIT, 2'b10, r[7:0]});
    rd(OFF_ACC, {24'h0, r[7:0]});
    rd(OFF_PC, {19'h0, t2});
    op({PAT_RET_LIT, 2'b00, ~r[7:0]});
    rd(OFF_PC, {19'h0, t1});
    rd(OFF_STATUS, 32'h1);
    done("return_with_literal");
    wr(OFF_STATUS, 32'h0);
    wr(OFF_STACK, {19'h0, t2});
    rd(OFF_STACK, {12'h0, 4'h1, 3'h0, t2});
    op(OPC_RET_IRQ);
    rd(OFF_PC, {19'h0, t2});
    ports(3'b011);
    rd(OFF_STATUS, 32'h10);
    done("return_from_irq");
    wr(OFF_PC, {19'h0, t1});
    wr(OFF_ACC, {24'h0, r[7:0]});
    wr(OFF_STATUS, 32'h3);
    op({7'h0, r[1:0], 5'h0});
    rd(OFF_PC, {19'h0, t1 + 13'h1});
    rd(OFF_ACC, {24'h0, r[7:0]});
    rd(OFF_STATUS, 32'h3);
    ports(3'b010);
    done("nop");
    wr(OFF_STATUS, 32'h08);
    op(OPC_SLEEP);
    ports(3'b100);
    rd(OFF_STATUS, 32'h64);
    rd(OFF_WDOG, 32'h0);
    op({PAT_LOAD_LIT, 2'b00, ~r[7:0]});
    rd(OFF_INSTR, {18'h0, OPC_SLEEP});
    rd(OFF_ACC, {24'h0, r[7:0]});
    rd(OFF_WDOG, 32'h0);
    wr(OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    ports(3'b010);
    done("sleep");
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h24, 32'h0);
    done("unmapped");
    print_verdict();
  end
endmodule

// ---- common/cmrs_pkg.sv ----
// Shared constants for the move, return, rotate and sleep execution block.
package cmrs_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int OPC_W = 14;
  localparam int PADDR_W = 8;
  localparam int FILE_DEPTH = 128;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [PADDR_W-1:0] OFF_INSTR = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_ACC = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_PC = 8'h0c;
  localparam logic [PADDR_W-1:0] OFF_STACK = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_WDOG = 8'h14;
  localparam logic [PADDR_W-1:0] OFF_FADDR = 8'h18;
  localparam logic [PADDR_W-1:0] OFF_FDATA = 8'h1c;
  localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h20;

  // ---------------------------------------------------------------
  // Status and control field positions
  // ---------------------------------------------------------------
  localparam int STB_CARRY = 0;
  localparam int STB_ZERO = 1;
  localparam int STB_EXPIRY = 2;
  localparam int STB_PDOWN = 3;
  localparam int STB_GIE = 4;
  localparam int STB_BUSY = 5;
  localparam int STB_SLEEP = 6;
  localparam int CTB_WAKE = 0;
  localparam int STACK_CNT_LSB = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RST_CARRY = 1'b0;
  localparam logic RST_ZERO = 1'b0;
  localparam logic RST_EXPIRY = 1'b1;
  localparam logic RST_PDOWN = 1'b1;
  localparam logic RST_GIE = 1'b0;
  localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
  localparam logic [PC_W-1:0] RST_PC = 13'h0000;
  localparam logic [DATA_W-1:0] WDOG_CLEAR = 8'h00;

  // ---------------------------------------------------------------
  // Instruction encodings
  // ---------------------------------------------------------------
  localparam logic [5:0] PAT_COPY_FILE = 6'h08;
  localparam logic [5:0] PAT_ROTATE = 6'h0d;
  localparam logic [6:0] PAT_STORE_ACC = 7'h01;
  localparam logic [3:0] PAT_LOAD_LIT = 4'hc;
  localparam logic [3:0] PAT_RET_LIT = 4'hd;
  localparam logic [OPC_W-1:0] OPC_RET_IRQ = 14'h0009;
  localparam logic [OPC_W-1:0] OPC_SLEEP = 14'h0063;
  localparam int DEST_BIT = 7;

  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_COPY_FILE = 3'b001,
    OP_LOAD_LIT = 3'b010,
    OP_STORE_ACC = 3'b011,
    OP_RET_LIT = 3'b100,
    OP_RET_IRQ = 3'b101,
    OP_ROTATE = 3'b110,
    OP_SLEEP = 3'b111
  } cmrs_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SECOND = 2'b10,
    ST_SLEEP = 2'b11
  } cmrs_state_t;

endpackage

// ---- design/cmrs_core.sv ----
// Execution unit for moves, returns, rotate and sleep, with an APB slave.
//
// Behaviour
// - Copy-file moves register f to accumulator if d is 0, else back to f.
// - Copy-file sets the zero flag from the moved value.
// - Load-literal puts the 8-bit immediate in the accumulator, flags kept.
// - Load-literal encodings decode regardless of the don't-care bits.
// - Store-accumulator writes the accumulator into register f, flags kept.
// - Return-with-literal loads accumulator, pops stack top into PC.
// - Return-with-literal takes two instruction cycles.
// - Rotate-left goes through carry; result to accumulator or f.
// - Sleep clears the powerdown status and sets the expiry flag.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep halts execution and stops the oscillator.
`timescale 1ns/1ps
module cmrs_core import cmrs_pkg::*; #(
  parameter int STACK_DEPTH = 8,
  parameter int PRESC_W = 8
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [PADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic OSC_RUN_OUT,
  output logic SLEEPING_OUT,
  output logic GIE_OUT
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic cmrs_op_t decode_op(input logic [OPC_W-1:0] opc);
    cmrs_op_t op;
    op = OP_NOP;
    if (opc[13:10] == PAT_LOAD_LIT) begin
      op = OP_LOAD_LIT;
    end else if (opc[13:10] == PAT_RET_LIT) begin
      op = OP_RET_LIT;
    end else if (opc[13:8] == PAT_COPY_FILE) begin
      op = OP_COPY_FILE;
    end else if (opc[13:8] == PAT_ROTATE) begin
      op = OP_ROTATE;
    end else if (opc[13:7] == PAT_STORE_ACC) begin
      op = OP_STORE_ACC;
    end else if (opc == OPC_RET_IRQ) begin
      op = OP_RET_IRQ;
    end else if (opc == OPC_SLEEP) begin
      op = OP_SLEEP;
    end
    return op;
  endfunction

  function automatic logic is_mapped(input logic [PADDR_W-1:0] a);
    return (a == OFF_INSTR) || (a == OFF_ACC) || (a == OFF_STATUS) ||
           (a == OFF_PC) || (a == OFF_STACK) || (a == OFF_WDOG) ||
           (a == OFF_FADDR) || (a == OFF_FDATA) || (a == OFF_CTRL);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cmrs_state_t state_reg;
  cmrs_state_t state_next;
  logic [OPC_W-1:0] instr_reg;
  logic [DATA_W-1:0] acc_reg;
  logic [PC_W-1:0] pc_reg;
  logic carry_reg;
  logic zero_reg;
  logic expiry_reg;
  logic pdown_reg;
  logic gie_reg;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp_reg;
  logic [SP_W:0] depth_reg;
  logic [DATA_W-1:0] wdog_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic [FADDR_W-1:0] faddr_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic osc_run_reg;
  logic sleeping_reg;

  // ---------------------------------------------------------------
  // Decode and datapath
  // ---------------------------------------------------------------
  cmrs_op_t op;
  logic exec;
  logic [FADDR_W-1:0] f_addr;
  logic dest_file;
  logic [DATA_W-1:0] literal;
  logic [DATA_W-1:0] f_data;
  logic [DATA_W-1:0] apb_f_data;
  logic [DATA_W-1:0] rot_val;
  logic [PC_W-1:0] stack_top;
  logic is_return;
  logic core_we;
  logic [DATA_W-1:0] core_wdata;
  logic file_we;
  logic [FADDR_W-1:0] file_waddr;
  logic [DATA_W-1:0] file_wdata;

  assign op = decode_op(instr_reg);
  assign exec = (state_reg == ST_EXEC);
  assign f_addr = instr_reg[FADDR_W-1:0];
  assign dest_file = instr_reg[DEST_BIT];
  assign literal = instr_reg[DATA_W-1:0];
  assign rot_val = {f_data[DATA_W-2:0], carry_reg};
  assign stack_top = stack_mem[sp_reg - SP_W'(1)];
  assign is_return = exec && (op == OP_RET_LIT || op == OP_RET_IRQ);

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // The answer is prepared in the first access cycle so that PRDATA and
  // PREADY come straight from flops; every transfer has one wait state.
  logic apb_first;
  logic apb_commit;
  logic wr_commit;
  logic wr_instr;
  logic wr_acc;
  logic wr_status;
  logic wr_pc;
  logic wr_stack;
  logic wr_faddr;
  logic wr_fdata;
  logic wr_wake;
  logic idle;

  assign idle = (state_reg == ST_IDLE);
  assign apb_first = PSEL_IN && PENABLE_IN && !pready_reg;
  assign apb_commit = PSEL_IN && PENABLE_IN && pready_reg;
  assign wr_commit = apb_commit && PWRITE_IN;
  assign wr_instr = wr_commit && (PADDR_IN == OFF_INSTR) && idle;
  assign wr_acc = wr_commit && (PADDR_IN == OFF_ACC) && idle;
  assign wr_status = wr_commit && (PADDR_IN == OFF_STATUS) && idle;
  assign wr_pc = wr_commit && (PADDR_IN == OFF_PC) && idle;
  assign wr_stack = wr_commit && (PADDR_IN == OFF_STACK) && idle;
  assign wr_faddr = wr_commit && (PADDR_IN == OFF_FADDR);
  assign wr_fdata = wr_commit && (PADDR_IN == OFF_FDATA) && idle;
  assign wr_wake = wr_commit && (PADDR_IN == OFF_CTRL) &&
                   PWDATA_IN[CTB_WAKE];

  // ---------------------------------------------------------------
  // File registers
  // ---------------------------------------------------------------
  always_comb begin
    core_we = 1'b0;
    core_wdata = f_data;
    if (exec) begin
      unique case (op)
        OP_COPY_FILE: begin
          core_we = dest_file;
          core_wdata = f_data;
        end
        OP_STORE_ACC: begin
          core_we = 1'b1;
          core_wdata = acc_reg;
        end
        OP_ROTATE: begin
          core_we = dest_file;
          core_wdata = rot_val;
        end
        OP_NOP, OP_LOAD_LIT, OP_RET_LIT, OP_RET_IRQ, OP_SLEEP: begin
          core_we = 1'b0;
        end
      endcase
    end
  end

  // Software writes to the file data register are only taken while idle,
  // so the core port never competes with them.
  assign file_we = core_we || wr_fdata;
  assign file_waddr = core_we ? f_addr : faddr_reg;
  assign file_wdata = core_we ? core_wdata : PWDATA_IN[DATA_W-1:0];

  cmrs_file_regs #(
    .DEPTH(FILE_DEPTH),
    .WIDTH(DATA_W),
    .AW(FADDR_W)
  ) u_file_regs (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .we_in(file_we),
    .waddr_in(file_waddr),
    .wdata_in(file_wdata),
    .raddr_a_in(f_addr),
    .rdata_a_out(f_data),
    .raddr_b_in(faddr_reg),
    .rdata_b_out(apb_f_data)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (wr_instr) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (is_return) begin
          state_next = ST_SECOND;
        end else if (op == OP_SLEEP) begin
          state_next = ST_SLEEP;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_SECOND: begin
        state_next = ST_IDLE;
      end
      ST_SLEEP: begin
        if (wr_wake) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      instr_reg <= '0;
    end else if (wr_instr) begin
      instr_reg <= PWDATA_IN[OPC_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      acc_reg <= RST_ACC;
    end else if (exec && op == OP_COPY_FILE && !dest_file) begin
      acc_reg <= f_data;
    end else if (exec && op == OP_ROTATE && !dest_file) begin
      acc_reg <= rot_val;
    end else if (exec && (op == OP_LOAD_LIT || op == OP_RET_LIT)) begin
      acc_reg <= literal;
    end else if (wr_acc) begin
      acc_reg <= PWDATA_IN[DATA_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Program counter and stack
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      pc_reg <= RST_PC;
    end else if (is_return) begin
      pc_reg <= stack_top;
    end else if (exec) begin
      pc_reg <= pc_reg + PC_W'(1);
    end else if (wr_pc) begin
      pc_reg <= PWDATA_IN[PC_W-1:0];
    end
  end

  // The stack is circular: popping an empty stack wraps, as the pointer
  // has no underflow guard; the depth count saturates at zero instead.
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      sp_reg <= '0;
      depth_reg <= '0;
    end else if (is_return) begin
      sp_reg <= sp_reg - SP_W'(1);
      if (depth_reg != '0) begin
        depth_reg <= depth_reg - (SP_W + 1)'(1);
      end
    end else if (wr_stack) begin
      sp_reg <= sp_reg + SP_W'(1);
      if (depth_reg != (SP_W + 1)'(STACK_DEPTH)) begin
        depth_reg <= depth_reg + (SP_W + 1)'(1);
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (wr_stack) begin
      stack_mem[sp_reg] <= PWDATA_IN[PC_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      carry_reg <= RST_CARRY;
      zero_reg <= RST_ZERO;
    end else if (exec && op == OP_COPY_FILE) begin
      zero_reg <= (f_data == '0);
    end else if (exec && op == OP_ROTATE) begin
      carry_reg <= f_data[DATA_W-1];
    end else if (wr_status) begin
      carry_reg <= PWDATA_IN[STB_CARRY];
      zero_reg <= PWDATA_IN[STB_ZERO];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      expiry_reg <= RST_EXPIRY;
      pdown_reg <= RST_PDOWN;
    end else if (exec && op == OP_SLEEP) begin
      expiry_reg <= 1'b1;
      pdown_reg <= 1'b0;
    end else if (wr_status) begin
      expiry_reg <= PWDATA_IN[STB_EXPIRY];
      pdown_reg <= PWDATA_IN[STB_PDOWN];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      gie_reg <= RST_GIE;
    end else if (exec && op == OP_RET_IRQ) begin
      gie_reg <= 1'b1;
    end else if (wr_status) begin
      gie_reg <= PWDATA_IN[STB_GIE];
    end
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  // The counter only advances while the core clock runs; with the
  // oscillator stopped it holds its cleared value.
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      presc_reg <= '0;
      wdog_reg <= WDOG_CLEAR;
    end else if (exec && op == OP_SLEEP) begin
      presc_reg <= '0;
      wdog_reg <= WDOG_CLEAR;
    end else if (state_reg != ST_SLEEP) begin
      presc_reg <= presc_reg + PRESC_W'(1);
      if (presc_reg == '1) begin
        wdog_reg <= wdog_reg + DATA_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Sleep outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      osc_run_reg <= 1'b1;
      sleeping_reg <= 1'b0;
    end else begin
      osc_run_reg <= (state_next != ST_SLEEP);
      sleeping_reg <= (state_next == ST_SLEEP);
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      faddr_reg <= '0;
    end else if (wr_faddr) begin
      faddr_reg <= PWDATA_IN[FADDR_W-1:0];
    end
  end

  always_comb begin
    prdata_next = '0;
    unique case (PADDR_IN)
      OFF_INSTR: prdata_next[OPC_W-1:0] = instr_reg;
      OFF_ACC: prdata_next[DATA_W-1:0] = acc_reg;
      OFF_STATUS: begin
        prdata_next[STB_CARRY] = carry_reg;
        prdata_next[STB_ZERO] = zero_reg;
        prdata_next[STB_EXPIRY] = expiry_reg;
        prdata_next[STB_PDOWN] = pdown_reg;
        prdata_next[STB_GIE] = gie_reg;
        prdata_next[STB_BUSY] = !idle;
        prdata_next[STB_SLEEP] = (state_reg == ST_SLEEP);
      end
      OFF_PC: prdata_next[PC_W-1:0] = pc_reg;
      OFF_STACK: begin
        prdata_next[PC_W-1:0] = stack_top;
        prdata_next[STACK_CNT_LSB +: SP_W + 1] = depth_reg;
      end
      OFF_WDOG: begin
        prdata_next[DATA_W-1:0] = wdog_reg;
        prdata_next[DATA_W +: PRESC_W] = presc_reg;
      end
      OFF_FADDR: prdata_next[FADDR_W-1:0] = faddr_reg;
      OFF_FDATA: prdata_next[DATA_W-1:0] = apb_f_data;
      default: prdata_next = '0;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= apb_first;
      pslverr_reg <= apb_first && !is_mapped(PADDR_IN);
      if (apb_first && !PWRITE_IN) begin
        prdata_reg <= prdata_next;
      end
    end
  end

  assign PRDATA_OUT = prdata_reg;
  assign PREADY_OUT = pready_reg;
  assign PSLVERR_OUT = pslverr_reg;
  assign OSC_RUN_OUT = osc_run_reg;
  assign SLEEPING_OUT = sleeping_reg;
  assign GIE_OUT = gie_reg;

endmodule

// ---- design/cmrs_file_regs.sv ----
// File register array with one write port and two read ports.
`timescale 1ns/1ps
module cmrs_file_regs #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 8,
  parameter int AW = 7
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_a_in,
  output logic [WIDTH-1:0] rdata_a_out,
  input wire logic [AW-1:0] raddr_b_in,
  output logic [WIDTH-1:0] rdata_b_out
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Clearing on reset keeps reads defined before software fills it.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (we_in) begin
      mem_reg[waddr_in] <= wdata_in;
    end
  end

  // ---------------------------------------------------------------
  // Read ports
  // ---------------------------------------------------------------
  assign rdata_a_out = mem_reg[raddr_a_in];
  assign rdata_b_out = mem_reg[raddr_b_in];

endmodule
